// file: hw/bridge_clock_reset_defines.vh
// constants for the bridge clock selection, clock mask and reset block
`ifndef BRIDGE_CLOCK_RESET_DEFINES_VH
`define BRIDGE_CLOCK_RESET_DEFINES_VH

// secondary clock fan-out
`define SEC_CLOCK_COUNT        10
`define SEC_MASK_RESET         10'h000

// configuration space of the primary port
`define CFG_ADDR_WIDTH         8
`define CFG_STD_FIRST          8'h00
`define CFG_STD_LAST           8'h3f
`define BRIDGE_CTRL_OFFSET     8'h3e
`define BRIDGE_CTRL_RESET      16'h0000
`define BRIDGE_CTRL_SEC_RESET  6

// mask loader states
`define MASK_ST_HOLD           2'h0
`define MASK_ST_SHIFT          2'h1
`define MASK_ST_DONE           2'h2

`endif

// file: hw/pin_sync.v
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter             WIDTH      = 1,
  parameter [WIDTH-1:0] RESET_VAL  = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // meta_r feeds only the second stage
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end

endmodule

// file: hw/mask_shifter.v
// serial shift register that collects the secondary clock disable mask
`timescale 1ns/100ps
`include "bridge_clock_reset_defines.vh"
module mask_shifter #(
  parameter WIDTH = `SEC_CLOCK_COUNT
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             clear,
  input  wire             shift_en,
  input  wire             bit_in,
  output reg  [WIDTH-1:0] mask,
  output reg              full
);

  localparam CW = $clog2(WIDTH + 1);

  reg [CW-1:0] count_r;

  // first bit received ends up in bit 0 once all bits are in
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mask    <= `SEC_MASK_RESET;
      count_r <= {CW{1'b0}};
      full    <= 1'b0;
    end else if (clear) begin
      mask    <= `SEC_MASK_RESET;
      count_r <= {CW{1'b0}};
      full    <= 1'b0;
    end else if (shift_en && !full) begin
      mask    <= {bit_in, mask[WIDTH-1:1]};
      count_r <= count_r + 1'b1;
      full    <= (count_r == WIDTH[CW-1:0] - 1'b1);
    end
  end

endmodule

// file: hw/bridge_clock_reset_control.v
// clock selection, secondary clock fan-out with serial mask, and reset distribution
//
// How it works
// - primary timing ticks from primary clock
// - secondary timing ticks from secondary clock input
// - strap low picks oscillator, high primary
// - mask sampling starts after primary reset release
// - mask bits shift into clock control register
// - mask held low keeps all clocks running
// - masked clocks run, then static high
// - primary reset floats outputs, error, grant
// - primary reset restores standard config defaults
// - primary reset three-states bus, no parking
// - primary reset asserts secondary reset
// - bridge control bit asserts secondary reset
`timescale 1ns/100ps
`include "bridge_clock_reset_defines.vh"
module bridge_clock_reset_control #(
  parameter NCLK = `SEC_CLOCK_COUNT
) (
  input  wire            clk,
  input  wire            reset,
  input  wire            primary_clock_in,
  input  wire            secondary_clock_in,
  input  wire            external_oscillator_in,
  input  wire            oscillator_select_n,
  input  wire            clock_mask_serial_in,
  input  wire            primary_reset_in_n,
  input  wire            cfg_wr_en,
  input  wire [7:0]      cfg_wr_addr,
  input  wire [15:0]     cfg_wr_data,
  output reg             primary_clock_tick_r,
  output reg             secondary_clock_tick_r,
  output reg  [NCLK-1:0] secondary_clock_out_r,
  output reg             secondary_reset_out_n_r,
  output reg             primary_output_enable_r,
  output reg             primary_system_error_oe_r,
  output reg             primary_grant_oe_r,
  output reg             primary_park_enable_r,
  output reg  [15:0]     bridge_control_r,
  output reg  [NCLK-1:0] clock_mask_r,
  output reg             mask_loaded_r
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  function rise;
    input now_lvl;
    input old_lvl;
    begin
      rise = now_lvl & ~old_lvl;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  wire [5:0] pins_sync;
  wire       pclk_s;
  wire       sclk_s;
  wire       osc_s;
  wire       osc_sel_n_s;
  wire       mask_in_s;
  wire       prst_n_s;

  // reset level of the reset pin stage is "asserted" so nothing runs early;
  // the strap stage starts high, so the primary clock is the source out of reset
  pin_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h10)
  ) u_pin_sync (
    .clk      (clk),
    .reset    (reset),
    .pin_in   ({clock_mask_serial_in, oscillator_select_n, primary_reset_in_n,
                external_oscillator_in, secondary_clock_in, primary_clock_in}),
    .sync_out (pins_sync)
  );

  assign pclk_s      = pins_sync[0];
  assign sclk_s      = pins_sync[1];
  assign osc_s       = pins_sync[2];
  assign prst_n_s    = ~pins_sync[3] ? 1'b0 : 1'b1;
  assign osc_sel_n_s = pins_sync[4];
  assign mask_in_s   = pins_sync[5];

  // ----------------------------------------------------------------
  // primary reset as an asynchronous clear
  // ----------------------------------------------------------------

  // the pin clears the drive enables at once, without waiting for clk;
  // release is taken from the synchronised copy so it is glitch free
  wire prst_async;

  assign prst_async = reset | ~primary_reset_in_n;

  // ----------------------------------------------------------------
  // clock edge detection
  // ----------------------------------------------------------------

  reg pclk_d_r;
  reg sclk_d_r;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pclk_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      pclk_d_r <= pclk_s;
      sclk_d_r <= sclk_s;
    end
  end

  wire pclk_rise;
  wire sclk_rise;

  assign pclk_rise = rise(pclk_s, pclk_d_r);
  assign sclk_rise = rise(sclk_s, sclk_d_r);

  // one-cycle enables for the bus interface logic of each port
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      primary_clock_tick_r   <= 1'b0;
      secondary_clock_tick_r <= 1'b0;
    end else begin
      primary_clock_tick_r   <= pclk_rise;
      secondary_clock_tick_r <= sclk_rise;
    end
  end

  // ----------------------------------------------------------------
  // bridge control register
  // ----------------------------------------------------------------

  wire ctrl_hit;

  assign ctrl_hit = cfg_wr_en && (cfg_wr_addr == `BRIDGE_CTRL_OFFSET);

  // the standard header follows the primary reset pin, not only reset;
  // the raw pin may lift the async clear at any moment, but the synchronous
  // branch keeps the register cleared until the synchronised copy follows,
  // so removal timing against clk never matters
  always @(posedge clk or posedge prst_async) begin
    if (prst_async) begin
      bridge_control_r <= `BRIDGE_CTRL_RESET;
    end else if (!prst_n_s) begin
      bridge_control_r <= `BRIDGE_CTRL_RESET;
    end else if (ctrl_hit) begin
      bridge_control_r <= cfg_wr_data;
    end
  end

  wire sec_reset_bit;

  assign sec_reset_bit = bridge_control_r[`BRIDGE_CTRL_SEC_RESET];

  // ----------------------------------------------------------------
  // primary pin drive enables
  // ----------------------------------------------------------------

  // enables drop at once on the raw pin and rise only from the synchronised
  // copy, so a glitch on the pin can float the bus but never drive it early
  always @(posedge clk or posedge prst_async) begin
    if (prst_async) begin
      primary_output_enable_r   <= 1'b0;
      primary_system_error_oe_r <= 1'b0;
      primary_grant_oe_r        <= 1'b0;
      primary_park_enable_r     <= 1'b0;
    end else begin
      primary_output_enable_r   <= prst_n_s;
      primary_system_error_oe_r <= prst_n_s;
      primary_grant_oe_r        <= prst_n_s;
      primary_park_enable_r     <= prst_n_s;
    end
  end

  // ----------------------------------------------------------------
  // clock mask loader
  // ----------------------------------------------------------------

  localparam [1:0] ST_HOLD  = `MASK_ST_HOLD;
  localparam [1:0] ST_SHIFT = `MASK_ST_SHIFT;
  localparam [1:0] ST_DONE  = `MASK_ST_DONE;

  reg  [1:0]      mask_state_r;
  reg  [1:0]      mask_state_nxt;
  wire [NCLK-1:0] shifter_mask;
  wire            shifter_full;
  wire            shift_clear;
  wire            shift_step;

  // a new primary reset always restarts the load from an empty mask
  assign shift_clear = !prst_n_s;
  // one bit per primary clock rise while secondary reset is still held
  assign shift_step  = (mask_state_r == ST_SHIFT) && pclk_rise;

  always @* begin
    mask_state_nxt = mask_state_r;
    case (mask_state_r)
      ST_HOLD: begin
        if (prst_n_s && !secondary_reset_out_n_r) begin
          mask_state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!prst_n_s) begin
          mask_state_nxt = ST_HOLD;
        end else if (shifter_full) begin
          mask_state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!prst_n_s) begin
          mask_state_nxt = ST_HOLD;
        end
      end
      default: begin
        mask_state_nxt = ST_HOLD;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_state_r <= ST_HOLD;
    end else begin
      mask_state_r <= mask_state_nxt;
    end
  end

  mask_shifter #(
    .WIDTH (NCLK)
  ) u_mask_shifter (
    .clk      (clk),
    .reset    (reset),
    .clear    (shift_clear),
    .shift_en (shift_step),
    .bit_in   (mask_in_s),
    .mask     (shifter_mask),
    .full     (shifter_full)
  );

  // the clock control register only takes the mask once all bits are in,
  // so a partly shifted pattern never stops a clock
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_mask_r  <= `SEC_MASK_RESET;
      mask_loaded_r <= 1'b0;
    end else if (!prst_n_s) begin
      clock_mask_r  <= `SEC_MASK_RESET;
      mask_loaded_r <= 1'b0;
    end else if (mask_state_r == ST_SHIFT && shifter_full) begin
      clock_mask_r  <= shifter_mask;
      mask_loaded_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // secondary clock source and fan-out
  // ----------------------------------------------------------------

  // the strap is read live; the board is trusted to tie it firmly,
  // a floating strap would switch the source mid-frame
  wire src_clk;

  assign src_clk = osc_sel_n_s ? pclk_s : osc_s;

  // outputs are a sampled copy of the source, so their high and low
  // phases are accurate only to one clk period
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      secondary_clock_out_r <= {NCLK{1'b0}};
    end else begin
      // zero bits keep the clock running, set bits park it high
      secondary_clock_out_r <= {NCLK{src_clk}} | clock_mask_r;
    end
  end

  // ----------------------------------------------------------------
  // secondary reset
  // ----------------------------------------------------------------

  // held through the mask load so downstream devices see stable clocks
  // before they leave reset
  wire sec_reset_req;

  assign sec_reset_req = !prst_n_s || sec_reset_bit || (mask_state_r != ST_DONE);

  always @(posedge clk or posedge prst_async) begin
    if (prst_async) begin
      secondary_reset_out_n_r <= 1'b0;
    end else if (sec_reset_req) begin
      secondary_reset_out_n_r <= 1'b0;
    end else begin
      secondary_reset_out_n_r <= 1'b1;
    end
  end

endmodule

// file: bench/crc_monitor.sv
// port-level assertion checker for the clock selection, mask and reset block
`timescale 1ns/100ps
module crc_monitor #(
  parameter NCLK = 10
) (
  input wire            clk,
  input wire            reset,
  input wire            primary_clock_in,
  input wire            secondary_clock_in,
  input wire            primary_reset_in_n,
  input wire            cfg_wr_en,
  input wire [7:0]      cfg_wr_addr,
  input wire [15:0]     cfg_wr_data,
  input wire            primary_clock_tick_r,
  input wire            secondary_clock_tick_r,
  input wire [NCLK-1:0] secondary_clock_out_r,
  input wire            secondary_reset_out_n_r,
  input wire            primary_output_enable_r,
  input wire            primary_system_error_oe_r,
  input wire            primary_grant_oe_r,
  input wire            primary_park_enable_r,
  input wire [15:0]     bridge_control_r,
  input wire [NCLK-1:0] clock_mask_r,
  input wire            mask_loaded_r
);
  wire prst = !primary_reset_in_n;
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  property p_srst; prst |-> !secondary_reset_out_n_r; endproperty
  a_srst: assert property (p_srst) else $error("sec reset out high");
  property p_oe;
    prst |-> !(primary_output_enable_r || primary_system_error_oe_r || primary_grant_oe_r);
  endproperty
  a_oe: assert property (p_oe) else $error("primary drive in reset");
  property p_park; prst |-> !primary_park_enable_r; endproperty
  a_park: assert property (p_park) else $error("parking in reset");
  property p_cfg; prst |-> bridge_control_r == 16'h0000; endproperty
  a_cfg: assert property (p_cfg) else $error("config not default");
  property p_bit; bridge_control_r[6] && $past(bridge_control_r[6]) |-> !secondary_reset_out_n_r;
  endproperty
  a_bit: assert property (p_bit) else $error("bit set, sec reset high");
  property p_wr;
    primary_reset_in_n [*4] ##0 (cfg_wr_en && cfg_wr_addr == 8'h3e)
      |=> prst || bridge_control_r == $past(cfg_wr_data);
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_ign; cfg_wr_en && cfg_wr_addr != 8'h3e |=> prst || $stable(bridge_control_r);
  endproperty
  a_ign: assert property (p_ign) else $error("other address changed control");
  property p_rel;
    (primary_reset_in_n && mask_loaded_r && !bridge_control_r[6]) [*3] |-> secondary_reset_out_n_r;
  endproperty
  a_rel: assert property (p_rel) else $error("sec reset not released");
  property p_hold; !mask_loaded_r |-> !secondary_reset_out_n_r; endproperty
  a_hold: assert property (p_hold) else $error("sec reset left before mask");
  property p_mhi;
    mask_loaded_r && $past(mask_loaded_r, 2) |-> (secondary_clock_out_r & clock_mask_r) == clock_mask_r;
  endproperty
  a_mhi: assert property (p_mhi) else $error("masked clock not high");
  // tick must follow a real pin rise and last one cycle
  property p_pt; primary_clock_tick_r
    |-> ($past(primary_clock_in) && !$past(primary_clock_in, 6)) ##1 !primary_clock_tick_r;
  endproperty
  a_pt: assert property (p_pt) else $error("primary tick");
  property p_st; secondary_clock_tick_r
    |-> ($past(secondary_clock_in) && !$past(secondary_clock_in, 6)) ##1 !secondary_clock_tick_r;
  endproperty
  a_st: assert property (p_st) else $error("secondary tick");
  c_load: cover property ($rose(mask_loaded_r));
  c_bit: cover property ($rose(bridge_control_r[6]));
  c_rel: cover property ($rose(secondary_reset_out_n_r));
endmodule

bind bridge_clock_reset_control crc_monitor #(.NCLK(NCLK)) mon_u (.*);

// file: bench/host_model.sv
// upstream host: primary clock and reset, serial mask stream, spare clocks
`timescale 1ns/100ps
module host_model (
  input  wire       hold,
  input  wire [9:0] mask_word,
  output reg        pclk = 1'b1,
  output reg        osc = 1'b0,
  output reg        sclk = 1'b0,
  output reg        prst_n = 1'b0,
  output reg        msk = 1'b0
);
  integer i;
  // the offset keeps every clock edge away from the bench clock edges
  initial begin
    #0.3;
    fork
      forever #62.5 pclk = ~pclk;
      forever #70 osc = ~osc;
      forever #50 sclk = ~sclk;
    join
  end
  initial begin
    forever begin
      @(negedge hold);
      @(negedge pclk);
      prst_n = 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
        msk = mask_word[i];
        @(negedge pclk);
      end
      msk = ~msk;
      @(posedge hold);
      prst_n = 1'b0;
    end
  end
endmodule

// file: bench/testbench.sv
// self-checking bench for the clock selection, mask and reset block
`timescale 1ns/100ps
module testbench;
  logic        clk;
  logic        reset = 1'b1;
  logic        hold = 1'b1;
  logic        oscillator_select_n = 1'b1;
  logic        cfg_wr_en = 1'b0;
  logic [7:0]  cfg_wr_addr = 8'h00;
  logic [15:0] cfg_wr_data = 16'h0000;
  logic [9:0]  mask_word = 10'h000;
  logic [9:0]  exp_mask = 10'h000;
  logic [9:0]  exp_out;
  logic [15:0] d;
  logic [31:0] rnd = 32'd63094;
  logic        was_loaded = 1'b0;
  logic        flat;
  logic        h[$];
  wire         primary_clock_in, secondary_clock_in, external_oscillator_in;
  wire         clock_mask_serial_in, primary_reset_in_n, primary_clock_tick_r;
  wire         secondary_clock_tick_r, secondary_reset_out_n_r, primary_output_enable_r;
  wire         primary_system_error_oe_r, primary_grant_oe_r, primary_park_enable_r;
  wire         mask_loaded_r;
  wire [9:0]   secondary_clock_out_r, clock_mask_r;
  wire [15:0]  bridge_control_r;
  int          error_cnt = 0, checks = 0, cyc = 0, np = 0, nt = 0, ns = 0, nst = 0, i, k;

  bridge_clock_reset_control dut_u (.*);
  host_model host_u (
    .hold      (hold),
    .mask_word (mask_word),
    .pclk      (primary_clock_in),
    .osc       (external_oscillator_in),
    .sclk      (secondary_clock_in),
    .prst_n    (primary_reset_in_n),
    .msk       (clock_mask_serial_in)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_wr_addr <= a;
    cfg_wr_data <= v;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic load(input logic [9:0] m);
    int n;
    @(posedge clk);
    mask_word <= m;
    hold <= 1'b0;
    exp_mask = m;
    for (n = 0; n < 300 && mask_loaded_r !== 1'b1; n++) begin
      @(negedge clk);
      chk(secondary_reset_out_n_r === 1'b0 || mask_loaded_r === 1'b1, "early release");
    end
    chk(clock_mask_r === m, "mask");
    @(negedge clk);
    chk(secondary_reset_out_n_r === 1'b1, "no release");
    chk({primary_output_enable_r, primary_system_error_oe_r} === 2'b11, "drive");
    chk({primary_grant_oe_r, primary_park_enable_r} === 2'b11, "grant, park on");
  endtask

  always @(posedge primary_clock_in) if (!reset) np++;
  always @(posedge primary_clock_tick_r) nt++;
  always @(posedge secondary_clock_in) if (!reset) ns++;
  always @(posedge secondary_clock_tick_r) nst++;

  always @(posedge clk) begin
    h.push_front(oscillator_select_n ? primary_clock_in : external_oscillator_in);
    if (h.size() > 8) void'(h.pop_back());
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test;
    end
  end

  // source is only judged where it sat still across the whole sync lag
  always @(negedge clk) begin
    if (!reset && h.size() > 6) begin
      flat = 1'b1;
      for (k = 2; k < 7; k++)
        flat = flat && (h[k] === h[1]);
      exp_out = {10{h[1]}} | (was_loaded ? exp_mask : 10'h000);
      if (flat && mask_loaded_r === was_loaded)
        chk(secondary_clock_out_r === exp_out, "clock out");
    end
    was_loaded <= mask_loaded_r;
  end

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wr(8'h3e, 16'hffff);
    chk(bridge_control_r === 16'h0000, "write in reset");
    chk(secondary_reset_out_n_r === 1'b0, "sec reset");
    chk({primary_output_enable_r, primary_system_error_oe_r} === 2'b00, "oe");
    chk({primary_grant_oe_r, primary_park_enable_r} === 2'b00, "grant, park");
    rnd = xs(rnd);
    load(rnd[9:0]);
    for (i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      d = {rnd[15:7], i[0], rnd[5:0]};
      wr(8'h3e, d);
      chk(bridge_control_r === d, "control write");
      chk(secondary_reset_out_n_r === ~i[0], "control bit");
      wr(8'h3c, ~d);
      chk(bridge_control_r === d, "other address");
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      oscillator_select_n <= i[0];
      @(negedge clk);
      h.delete();
      repeat (300) @(posedge clk);
    end
    @(posedge clk);
    hold <= 1'b1;
    #1;
    chk(secondary_reset_out_n_r === 1'b0, "async sec reset");
    chk(bridge_control_r === 16'h0000, "async config");
    chk({primary_output_enable_r, primary_park_enable_r} === 2'b00, "async drive");
    repeat (20) @(posedge clk);
    load(10'h000);
    repeat (300) @(posedge clk);
    chk((np - nt) inside {[0:1]}, "primary ticks");
    chk((ns - nst) inside {[0:1]}, "secondary ticks");
    end_of_test;
  end
endmodule
